/* verilog/snsi_pkg.sv */
package snsi_pkg;

	// shared area geometry
	localparam int            MOD_COUNT       = 3;
	localparam int            REC_WORDS       = 8;
	localparam int            AREA_WORDS      = MOD_COUNT * REC_WORDS;
	localparam int            BASE_W          = 15;
	localparam int            ADDR_W          = 16;
	localparam int            WORD_W          = 16;
	localparam int            IDX_W           = 2;
	localparam int            SEL_W           = 3;
	localparam int            REC_SHIFT       = 3;

	// setting ranges and defaults
	localparam logic [14:0]   AREA_BASE_DFLT  = 15'h3e94;
	localparam logic [1:0]    MOD_INDEX_DFLT  = 2'h0;
	localparam logic [1:0]    MOD_INDEX_MAX   = 2'h2;

	// record word offsets
	localparam logic [2:0]    W_UNIT          = 3'h0;
	localparam logic [2:0]    W_MOD_STAT      = 3'h1;
	localparam logic [2:0]    W_CPU_STAT      = 3'h2;
	localparam logic [2:0]    W_CHECK         = 3'h7;

	// unit address word
	localparam logic [7:0]    UNIT_ADDR_BIAS  = 8'h10;
	localparam logic [7:0]    UNIT_ADDR_HIGH  = 8'h00;

	// module run status bit positions
	localparam int            MS_RUN          = 0;
	localparam int            MS_PV_ERR       = 1;
	localparam int            MS_MV_ERR       = 2;
	localparam int            MS_EXEC_ERR     = 3;
	localparam int            MS_FBDB_ERR     = 4;
	localparam int            MS_BATT_ERR     = 5;
	localparam int            MS_PARTIAL_DL   = 15;

	// host cpu status bit positions, bit 5 unused
	localparam int            CS_FATAL        = 0;
	localparam int            CS_RUNNING      = 1;
	localparam int            CS_OUT_OFF      = 2;
	localparam int            CS_RUN_MODE     = 3;
	localparam int            CS_MON_MODE     = 4;
	localparam int            CS_PROG_MODE    = 6;

	typedef struct packed {
		logic process_value_err;
		logic manipulated_value_err;
		logic exec_err;
		logic fbdb_err;
		logic batt_err;
	} snsi_mod_err_t;

	typedef struct packed {
		logic fatal;
		logic running;
		logic out_off;
		logic run_mode;
		logic mon_mode;
		logic prog_mode;
	} snsi_cpu_stat_t;

	typedef struct packed {
		logic           running;
		logic           partial_dl;
		snsi_mod_err_t  err;
		snsi_cpu_stat_t cpu;
		logic [3:0]     unit_number;
		logic [15:0]    check_code;
	} snsi_snap_t;

endpackage : snsi_pkg

/* verilog/snsi_rise_det.sv */
`timescale 1ns/1ps
module snsi_rise_det (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic level,
	output logic      rise
);
	logic prev_ff;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= level;
		end
	end

	assign rise = level & ~prev_ff;
endmodule : snsi_rise_det

/* verilog/snsi_word_mux.sv */
`timescale 1ns/1ps
module snsi_word_mux (
	input  wire logic [snsi_pkg::SEL_W-1:0]  sel,
	input  wire snsi_pkg::snsi_snap_t        snap,
	output logic      [snsi_pkg::WORD_W-1:0] word
);
	import snsi_pkg::*;

	always_comb begin
		word = '0;
		unique case (sel)
			W_UNIT: begin
				word = {UNIT_ADDR_HIGH, UNIT_ADDR_BIAS + {4'h0, snap.unit_number}};
			end
			W_MOD_STAT: begin
				word[MS_RUN]        = snap.running;
				word[MS_PV_ERR]     = snap.err.process_value_err;
				word[MS_MV_ERR]     = snap.err.manipulated_value_err;
				word[MS_EXEC_ERR]   = snap.err.exec_err;
				word[MS_FBDB_ERR]   = snap.err.fbdb_err;
				word[MS_BATT_ERR]   = snap.err.batt_err;
				word[MS_PARTIAL_DL] = snap.partial_dl;
			end
			W_CPU_STAT: begin
				word[CS_FATAL]     = snap.cpu.fatal;
				word[CS_RUNNING]   = snap.cpu.running;
				word[CS_OUT_OFF]   = snap.cpu.out_off;
				word[CS_RUN_MODE]  = snap.cpu.run_mode;
				word[CS_MON_MODE]  = snap.cpu.mon_mode;
				word[CS_PROG_MODE] = snap.cpu.prog_mode;
			end
			W_CHECK: begin
				word = snap.check_code;
			end
			default: begin
				word = '0;
			end
		endcase
	end
endmodule : snsi_word_mux

/* verilog/snsi_writer.sv */
`timescale 1ns/1ps
// Functional notes
// - area base from setting, 0..32767, default 16020
// - module index setting 0..2, at most three
// - area starts with three 8-word records
// - record written when the module starts running
// - record at base plus eight times index
// - word 0 is unit number plus 10h
// - word 1 bit 0 shows running
// - word 1 bits 1,2 follow value error inputs
// - word 1 bits 3..5 flag unit errors
// - bit 15 set on partial download, cleared on restart
// - word 2 bits 0..2 mirror host cpu state
// - word 2 bits 3,4,6 show host mode
// - word 7 carries a system check code
module snsi_writer (
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	input  wire logic [snsi_pkg::BASE_W-1:0]   area_base_setting,
	input  wire logic [snsi_pkg::IDX_W-1:0]    module_index_setting,
	input  wire logic [3:0]                    unit_number,
	input  wire logic                          module_running,
	input  wire snsi_pkg::snsi_mod_err_t       mod_err,
	input  wire snsi_pkg::snsi_cpu_stat_t      cpu_stat,
	input  wire logic                          partial_download,
	input  wire logic                          restart,
	input  wire logic                          mem_ready,
	output logic                               mem_req_ff,
	output logic      [snsi_pkg::ADDR_W-1:0]   mem_addr_ff,
	output logic      [snsi_pkg::WORD_W-1:0]   mem_wdata_ff,
	output logic                               rec_done_ff,
	output logic                               index_err_ff
);
	import snsi_pkg::*;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} snsi_state_t;

	// first word of the record owned by one module index
	function automatic logic [ADDR_W-1:0] rec_start(
		input logic [BASE_W-1:0] base,
		input logic [IDX_W-1:0]  idx
	);
		logic [ADDR_W-1:0] off;
		off = {{(ADDR_W-IDX_W-REC_SHIFT){1'b0}}, idx, {REC_SHIFT{1'b0}}};
		rec_start = {1'b0, base} + off;
	endfunction : rec_start

	function automatic logic index_ok(input logic [IDX_W-1:0] idx);
		index_ok = (idx <= MOD_INDEX_MAX);
	endfunction : index_ok

	localparam logic [SEL_W-1:0] LAST_WORD = SEL_W'(REC_WORDS - 1);

	snsi_state_t       state_ff;
	snsi_state_t       nxt_state;
	logic [SEL_W-1:0]  word_cnt_ff;
	logic [SEL_W-1:0]  nxt_word_cnt;
	logic [SEL_W-1:0]  mux_sel;
	logic [WORD_W-1:0] mux_word;
	logic              partial_dl_ff;
	logic [WORD_W-1:0] check_code_ff;
	snsi_snap_t        snap_ff;
	snsi_snap_t        mux_snap;
	logic              run_rise;
	logic              start;
	logic              advance;
	logic              last_beat;

	snsi_rise_det u_run_rise (
		.clk_sys (clk_sys),
		.rst     (rst),
		.level   (module_running),
		.rise    (run_rise)
	);

	// a start while a record is in flight is dropped; run cannot restart that fast
	assign start     = run_rise && (state_ff == ST_IDLE) && index_ok(module_index_setting);
	assign advance   = mem_req_ff && mem_ready;
	assign last_beat = advance && (word_cnt_ff == LAST_WORD);

	// first word is built from the live inputs, later ones from the snapshot
	always_comb begin
		mux_snap             = snap_ff;
		mux_sel              = nxt_word_cnt;
		if (start) begin
			mux_snap.running     = 1'b1;
			mux_snap.partial_dl  = partial_dl_ff;
			mux_snap.err         = mod_err;
			mux_snap.cpu         = cpu_stat;
			mux_snap.unit_number = unit_number;
			mux_snap.check_code  = check_code_ff;
		end
	end

	snsi_word_mux u_word_mux (
		.sel  (mux_sel),
		.snap (mux_snap),
		.word (mux_word)
	);

	always_comb begin
		nxt_state    = state_ff;
		nxt_word_cnt = word_cnt_ff;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_word_cnt = W_UNIT;
				if (start) begin
					nxt_state = ST_SEND;
				end
			end
			ST_SEND: begin
				if (last_beat) begin
					nxt_state    = ST_IDLE;
					nxt_word_cnt = W_UNIT;
				end else if (advance) begin
					nxt_word_cnt = word_cnt_ff + SEL_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff    <= ST_IDLE;
			word_cnt_ff <= W_UNIT;
		end else begin
			state_ff    <= nxt_state;
			word_cnt_ff <= nxt_word_cnt;
		end
	end

	// status inputs are snapshotted once per record so all its words agree
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			snap_ff <= '0;
		end else if (start) begin
			snap_ff <= mux_snap;
		end
	end

	// write port toward host memory
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mem_req_ff   <= 1'b0;
			mem_addr_ff  <= '0;
			mem_wdata_ff <= '0;
		end else if (start) begin
			mem_req_ff   <= 1'b1;
			mem_addr_ff  <= rec_start(area_base_setting, module_index_setting);
			mem_wdata_ff <= mux_word;
		end else if (last_beat) begin
			mem_req_ff   <= 1'b0;
		end else if (advance) begin
			mem_addr_ff  <= mem_addr_ff + ADDR_W'(1);
			mem_wdata_ff <= mux_word;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rec_done_ff <= 1'b0;
		end else begin
			rec_done_ff <= last_beat;
		end
	end

	// out-of-range index blocks the write rather than hitting a neighbour's slot
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			index_err_ff <= 1'b0;
		end else if (run_rise && (state_ff == ST_IDLE)) begin
			index_err_ff <= !index_ok(module_index_setting);
		end
	end

	// set wins over a restart in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			partial_dl_ff <= 1'b0;
		end else if (partial_download) begin
			partial_dl_ff <= 1'b1;
		end else if (restart) begin
			partial_dl_ff <= 1'b0;
		end
	end

	// changes with every record so a reader can spot a fresh write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			check_code_ff <= '0;
		end else if (last_beat) begin
			check_code_ff <= check_code_ff + WORD_W'(1);
		end
	end

	property p_start_addr;
		@(posedge clk_sys) disable iff (rst)
		start |=> mem_req_ff && (mem_addr_ff ==
			rec_start($past(area_base_setting), $past(module_index_setting)));
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("record start address wrong");

	property p_unit_word;
		@(posedge clk_sys) disable iff (rst)
		start |=> mem_wdata_ff == {UNIT_ADDR_HIGH, UNIT_ADDR_BIAS + {4'h0, $past(unit_number)}};
	endproperty
	a_unit_word: assert property (p_unit_word) else $error("unit address word wrong");

	property p_bad_index;
		@(posedge clk_sys) disable iff (rst)
		(run_rise && (state_ff == ST_IDLE) && (module_index_setting > MOD_INDEX_MAX))
			|=> !mem_req_ff && index_err_ff;
	endproperty
	a_bad_index: assert property (p_bad_index) else $error("bad index not refused");

	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		(mem_req_ff && !mem_ready) |=> mem_req_ff && $stable(mem_addr_ff) && $stable(mem_wdata_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed while stalled");

	property p_step;
		@(posedge clk_sys) disable iff (rst)
		(advance && !last_beat) |=> mem_req_ff && (mem_addr_ff == $past(mem_addr_ff) + ADDR_W'(1));
	endproperty
	a_step: assert property (p_step) else $error("address did not step");

	// beats accepted since the record began, counted apart from the word pointer
	localparam logic [SEL_W:0] BEATS_LAST = (SEL_W+1)'(REC_WORDS - 1);
	logic [SEL_W:0]            beats_ff;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			beats_ff <= '0;
		end else if (start) begin
			beats_ff <= '0;
		end else if (advance) begin
			beats_ff <= beats_ff + (SEL_W+1)'(1);
		end
	end

	property p_eight_words;
		@(posedge clk_sys) disable iff (rst)
		last_beat |-> beats_ff == BEATS_LAST;
	endproperty
	a_eight_words: assert property (p_eight_words) else $error("record not eight words long");

	property p_cpu_state;
		@(posedge clk_sys) disable iff (rst)
		(mem_req_ff && (word_cnt_ff == W_CPU_STAT)) |->
			(mem_wdata_ff[CS_FATAL] == snap_ff.cpu.fatal)
			&& (mem_wdata_ff[CS_RUNNING] == snap_ff.cpu.running)
			&& (mem_wdata_ff[CS_OUT_OFF] == snap_ff.cpu.out_off);
	endproperty
	a_cpu_state: assert property (p_cpu_state) else $error("cpu state bits wrong");

	property p_end;
		@(posedge clk_sys) disable iff (rst)
		last_beat |=> !mem_req_ff && rec_done_ff ##1 !rec_done_ff;
	endproperty
	a_end: assert property (p_end) else $error("record did not end after word 7");

	property p_run_bit;
		@(posedge clk_sys) disable iff (rst)
		(mem_req_ff && (word_cnt_ff == W_MOD_STAT)) |->
			mem_wdata_ff[MS_RUN] && (mem_wdata_ff[MS_PV_ERR] == snap_ff.err.process_value_err)
			&& (mem_wdata_ff[MS_MV_ERR] == snap_ff.err.manipulated_value_err);
	endproperty
	a_run_bit: assert property (p_run_bit) else $error("module status word wrong");

	property p_cpu_word;
		@(posedge clk_sys) disable iff (rst)
		(mem_req_ff && (word_cnt_ff == W_CPU_STAT)) |->
			(mem_wdata_ff[CS_RUN_MODE] == snap_ff.cpu.run_mode) && !mem_wdata_ff[5]
			&& (mem_wdata_ff[CS_PROG_MODE] == snap_ff.cpu.prog_mode);
	endproperty
	a_cpu_word: assert property (p_cpu_word) else $error("cpu status word wrong");

	property p_reserved;
		@(posedge clk_sys) disable iff (rst)
		(mem_req_ff && (word_cnt_ff > W_CPU_STAT) && (word_cnt_ff < W_CHECK)) |-> mem_wdata_ff == '0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved word not zero");

	property p_partial_set;
		@(posedge clk_sys) disable iff (rst)
		partial_download |=> partial_dl_ff;
	endproperty
	a_partial_set: assert property (p_partial_set) else $error("partial flag not set");

	property p_partial_clr;
		@(posedge clk_sys) disable iff (rst)
		(restart && !partial_download) |=> !partial_dl_ff ##1 (partial_dl_ff == $past(partial_download));
	endproperty
	a_partial_clr: assert property (p_partial_clr) else $error("partial flag not cleared");

	property p_check_step;
		@(posedge clk_sys) disable iff (rst)
		last_beat |=> check_code_ff == $past(check_code_ff) + WORD_W'(1);
	endproperty
	a_check_step: assert property (p_check_step) else $error("check code did not change");

endmodule : snsi_writer

/* test/snsi_host_mem.sv */
`timescale 1ns/1ps
module snsi_host_mem (
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	input  wire logic                        slow,
	input  wire logic                        mem_req_ff,
	input  wire logic [snsi_pkg::ADDR_W-1:0] mem_addr_ff,
	input  wire logic [snsi_pkg::WORD_W-1:0] mem_wdata_ff,
	output logic                             mem_ready
);
	import snsi_pkg::*;
	logic [WORD_W-1:0] mem [0:65535];
	// untouched words read as all ones, so zero writes are visible
	initial begin
		foreach (mem[i])
			mem[i] = 16'hffff;
	end
	// slow mode stalls every other cycle to stretch each word
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			mem_ready <= 1'b0;
		else
			mem_ready <= slow ? ~mem_ready : 1'b1;
	end
	// host keeps record words for the writer only
	always @(posedge clk_sys) begin
		if (mem_req_ff && mem_ready)
			mem[mem_addr_ff] <= mem_wdata_ff;
	end
endmodule : snsi_host_mem

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import snsi_pkg::*;
	logic                 clk_sys, rst, module_running, partial_download, restart, slow;
	logic [BASE_W-1:0]    area_base_setting;
	logic [IDX_W-1:0]     module_index_setting;
	logic [3:0]           unit_number;
	snsi_mod_err_t        mod_err;
	snsi_cpu_stat_t       cpu_stat;
	logic                 mem_ready, mem_req_ff, rec_done_ff, index_err_ff;
	logic [ADDR_W-1:0]    mem_addr_ff;
	logic [WORD_W-1:0]    mem_wdata_ff;
	int                   failures, n_compared, cycles;

	snsi_writer snsi_writer_i (.clk_sys(clk_sys), .rst(rst),
		.area_base_setting(area_base_setting), .module_index_setting(module_index_setting),
		.unit_number(unit_number), .module_running(module_running), .mod_err(mod_err),
		.cpu_stat(cpu_stat), .partial_download(partial_download), .restart(restart),
		.mem_ready(mem_ready), .mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff),
		.mem_wdata_ff(mem_wdata_ff), .rec_done_ff(rec_done_ff), .index_err_ff(index_err_ff));
	snsi_host_mem snsi_host_mem_i (.clk_sys(clk_sys), .rst(rst), .slow(slow),
		.mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff),
		.mem_ready(mem_ready));

	task automatic summarize;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic run_rec(input logic [1:0] idx, input logic [3:0] unit, input snsi_mod_err_t e,
		input snsi_cpu_stat_t c, input logic pd, input logic [15:0] code, input logic slw);
		logic [15:0] a;
		int n;
		@(posedge clk_sys);
		module_index_setting <= idx;
		unit_number <= unit;
		mod_err <= e;
		cpu_stat <= c;
		slow <= slw;
		@(posedge clk_sys);
		module_running <= 1'b1;
		n = 0;
		@(negedge clk_sys);
		while (rec_done_ff !== 1'b1 && n < 60) begin
			@(negedge clk_sys);
			n++;
		end
		chk("rec_done", {15'h0, rec_done_ff}, 16'h0001);
		chk("index_clear", {15'h0, index_err_ff}, 16'h0000);
		@(posedge clk_sys);
		module_running <= 1'b0;
		a = {1'b0, area_base_setting} + {11'h0, idx, 3'h0};
		chk("unit", snsi_host_mem_i.mem[a], {8'h00, 8'h10 + {4'h0, unit}});
		chk("mod_stat", snsi_host_mem_i.mem[a + 16'h1], {pd, 9'h0, e.batt_err, e.fbdb_err,
			e.exec_err, e.manipulated_value_err, e.process_value_err, 1'b1});
		chk("cpu_stat", snsi_host_mem_i.mem[a + 16'h2], {9'h0, c.prog_mode, 1'b0, c.mon_mode,
			c.run_mode, c.out_off, c.running, c.fatal});
		for (int w = 3; w < 7; w++)
			chk("reserved", snsi_host_mem_i.mem[a + 16'(w)], 16'h0000);
		chk("check_code", snsi_host_mem_i.mem[a + 16'h7], code);
		chk("area_end", snsi_host_mem_i.mem[{1'b0, area_base_setting} + 16'(AREA_WORDS)],
			16'hffff);
	endtask : run_rec

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// hang guard, a full run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		rst = 1'b1;
		area_base_setting = AREA_BASE_DFLT;
		module_index_setting = MOD_INDEX_DFLT;
		{unit_number, module_running, partial_download, restart, slow} = '0;
		mod_err = '0;
		cpu_stat = '0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		// every index, error bit and cpu bit in turn, stalls on odd passes
		for (int k = 0; k < 6; k++)
			run_rec(2'(k % 3), 4'(k * 3), 5'h1 << (k % 5), 6'h1 << k, 1'b0, 16'(k), k[0]);
		// last index 0 pass at the default base carried unit 9
		chk("dflt_rec", snsi_host_mem_i.mem[16'd16020], 16'h0019);
		@(posedge clk_sys);
		area_base_setting <= 15'h7fff;
		partial_download <= 1'b1;
		@(posedge clk_sys);
		partial_download <= 1'b0;
		run_rec(2'h2, 4'hf, '1, '1, 1'b1, 16'h6, 1'b1);
		@(posedge clk_sys);
		restart <= 1'b1;
		@(posedge clk_sys);
		restart <= 1'b0;
		run_rec(2'h1, 4'h5, '0, '0, 1'b0, 16'h7, 1'b0);
		@(posedge clk_sys);
		module_index_setting <= 2'h3;
		module_running <= 1'b1;
		repeat (12) @(negedge clk_sys);
		chk("index_err", {15'h0, index_err_ff}, 16'h0001);
		chk("no_write", snsi_host_mem_i.mem[16'h7fff + 16'd24], 16'hffff);
		@(posedge clk_sys);
		module_running <= 1'b0;
		summarize();
	end
endmodule : tb_top
